// file: design/gpcs_pkg.sv
// Package for the gigabit PHY control and status register group.
// Assumes the management frame decoder presents one register access per strobe.
package gpcs_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_GIG_CONTROL = 5'h09;
   localparam logic [4:0] ADDR_GIG_STATUS = 5'h0a;
   localparam logic [4:0] ADDR_GIG_STATUS_EXT_ONE = 5'h0f;
   localparam logic [4:0] ADDR_FAST_ETH_STATUS_EXT = 5'h10;

   // ----------------------------------------------------------------
   // gigabit_control field positions
   // ----------------------------------------------------------------
   localparam int CTL_TEST_MODE_LSB = 13;
   localparam int CTL_MS_MANUAL = 12;
   localparam int CTL_MS_VALUE = 11;
   localparam int CTL_PORT_MULTI = 10;
   localparam int CTL_ADV_FDX = 9;
   localparam int CTL_ADV_HDX = 8;

   // Reset value, with the two advertisement bits later replaced by the strap
   localparam logic [15:0] CTL_RESET = 16'h0400;

   // ----------------------------------------------------------------
   // gigabit_status field positions
   // ----------------------------------------------------------------
   localparam int GST_MS_FAULT = 15;
   localparam int GST_MS_MASTER = 14;
   localparam int GST_LOCAL_RX = 13;
   localparam int GST_REMOTE_RX = 12;
   localparam int GST_LP_FDX = 11;
   localparam int GST_LP_HDX = 10;
   localparam int GST_IDLE_CNT_LSB = 0;
   localparam int IDLE_CNT_W = 8;
   localparam logic [7:0] IDLE_CNT_MAX = 8'hff;
   localparam logic MS_MASTER_RESET = 1'b1;

   // ----------------------------------------------------------------
   // gigabit_status_ext_one: fixed capabilities
   // ----------------------------------------------------------------
   localparam logic [15:0] GST_EXT_ONE_VALUE = 16'h3000;

   // ----------------------------------------------------------------
   // fast_ethernet_status_ext field positions
   // ----------------------------------------------------------------
   localparam int FST_LOCKED = 15;
   localparam int FST_LOCK_ERR = 14;
   localparam int FST_DISCONNECT = 13;
   localparam int FST_LINK = 12;
   localparam int FST_RX_ERR = 11;
   localparam int FST_TX_ERR = 10;
   localparam int FST_SSD_ERR = 9;
   localparam int FST_ESD_ERR = 8;

   // ----------------------------------------------------------------
   // Transmitter test-mode codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TM_NORMAL = 3'b000,
      TM_WAVEFORM = 3'b001,
      TM_JITTER_MASTER = 3'b010,
      TM_JITTER_SLAVE = 3'b011,
      TM_DISTORTION = 3'b100
   } gpcs_test_mode_t;

endpackage

// file: design/gpcs_regs.sv
// Control and status registers of the gigabit twisted-pair side of the PHY.
// Assumes register accesses and all status inputs come from logic on MCLK.
//
// Behaviour
// - Test-mode field 000 normal; 001..100 waveform, jitter master, jitter slave, distortion.
// - Manual master/slave enable overrides automatic resolution; resets to zero.
// - Master/slave value honoured only with manual enable; one master, zero slave.
// - Port-type bit one means multi-port, zero single-port; resets to one.
// - Two writable 1000BASE-T advertisement bits reset from the strap value.
// - Master/slave fault bit latches high until read, resets to zero.
// - Resolution bit reads one for master, zero for slave; resets to one.
// - Local receiver status bit reads one while operating normally; resets zero.
// - Remote receiver status bit reads one when remote reports OK; resets zero.
// - Two bits report link partner 1000BASE-T full/half capability; reset zero.
// - Eight-bit idle error count clears on read; resets to zero.
// - Fixed register: 1000BASE-X unsupported, 1000BASE-T full and half supported.
// - Descrambler locked bit reads one while locked; resets to zero.
// - Lock error flag sets on detection, clears on read.
// - Disconnect flag sets on detection, clears on read.
// - Link status bit shows live 100BASE-TX link, no latching.
// - Receive and transmit error flags set on detection, clear on read.
// - Start and end stream delimiter error flags set on detection, clear on read.
module gpcs_regs (
   input wire logic MCLK,
   input wire logic RST,
   // Register access from the management interface
   input wire logic [4:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   // Strap sampling result: [1] full duplex, [0] half duplex
   input wire logic [1:0] CONFIG_STRAP_VALUE,
   // Controls toward negotiation and the transmitter
   output logic [2:0] TEST_MODE,
   output logic MS_MANUAL,
   output logic MS_REQ_MASTER,
   output logic PORT_MULTI,
   output logic ADV_1000T_FDX,
   output logic ADV_1000T_HDX,
   // Gigabit status from the PHY core
   input wire logic MS_FAULT_EVT,
   input wire logic MS_RESOLVED_MASTER,
   input wire logic LOCAL_RX_OK,
   input wire logic REMOTE_RX_OK,
   input wire logic LINK_PARTNER_1000T_FDX,
   input wire logic LINK_PARTNER_1000T_HDX,
   input wire logic IDLE_ERR_EVT,
   // 100BASE-TX status from the PHY core
   input wire logic FE_LOCKED,
   input wire logic FE_LOCK_ERR_EVT,
   input wire logic FE_DISCONNECT_EVT,
   input wire logic FE_LINK_UP,
   input wire logic FE_RX_ERR_EVT,
   input wire logic FE_TX_ERR_EVT,
   input wire logic FE_START_STREAM_DELIMITER_ERR_EVT,
   input wire logic FE_END_STREAM_DELIMITER_ERR_EVT
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] ctrl;
      logic ms_req_master;
      logic ms_fault;
      logic ms_master;
      logic local_rx;
      logic remote_rx;
      logic lp_fdx;
      logic lp_hdx;
      logic [7:0] idle_cnt;
      logic fe_locked;
      logic fe_lock_err;
      logic fe_disc;
      logic fe_link;
      logic fe_rx_err;
      logic fe_tx_err;
      logic fe_ssd_err;
      logic fe_esd_err;
      logic [15:0] rdata;
   } gpcs_state_t;

   gpcs_state_t st;
   gpcs_state_t next_st;

   logic rd_gst;
   logic rd_fst;
   logic [15:0] gst_word;
   logic [15:0] fst_word;

   // ----------------------------------------------------------------
   // Read views
   // ----------------------------------------------------------------
   always_comb begin
      gst_word = 16'h0000;
      gst_word[gpcs_pkg::GST_MS_FAULT] = st.ms_fault;
      gst_word[gpcs_pkg::GST_MS_MASTER] = st.ms_master;
      gst_word[gpcs_pkg::GST_LOCAL_RX] = st.local_rx;
      gst_word[gpcs_pkg::GST_REMOTE_RX] = st.remote_rx;
      gst_word[gpcs_pkg::GST_LP_FDX] = st.lp_fdx;
      gst_word[gpcs_pkg::GST_LP_HDX] = st.lp_hdx;
      gst_word[gpcs_pkg::GST_IDLE_CNT_LSB +: gpcs_pkg::IDLE_CNT_W] = st.idle_cnt;
      fst_word = 16'h0000;
      fst_word[gpcs_pkg::FST_LOCKED] = st.fe_locked;
      fst_word[gpcs_pkg::FST_LOCK_ERR] = st.fe_lock_err;
      fst_word[gpcs_pkg::FST_DISCONNECT] = st.fe_disc;
      fst_word[gpcs_pkg::FST_LINK] = st.fe_link;
      fst_word[gpcs_pkg::FST_RX_ERR] = st.fe_rx_err;
      fst_word[gpcs_pkg::FST_TX_ERR] = st.fe_tx_err;
      fst_word[gpcs_pkg::FST_SSD_ERR] = st.fe_ssd_err;
      fst_word[gpcs_pkg::FST_ESD_ERR] = st.fe_esd_err;
   end

   assign rd_gst = REG_RD && (REG_ADDR == gpcs_pkg::ADDR_GIG_STATUS);
   assign rd_fst = REG_RD && (REG_ADDR == gpcs_pkg::ADDR_FAST_ETH_STATUS_EXT);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;

      // Control register; reserved low byte is kept as plain storage
      if (REG_WR && (REG_ADDR == gpcs_pkg::ADDR_GIG_CONTROL)) begin
         next_st.ctrl = REG_WDATA;
      end
      // Negotiation only sees a role request while manual mode is on
      next_st.ms_req_master = next_st.ctrl[gpcs_pkg::CTL_MS_MANUAL]
                              & next_st.ctrl[gpcs_pkg::CTL_MS_VALUE];

      // Live status, one register stage
      next_st.ms_master = MS_RESOLVED_MASTER;
      next_st.local_rx = LOCAL_RX_OK;
      next_st.remote_rx = REMOTE_RX_OK;
      next_st.lp_fdx = LINK_PARTNER_1000T_FDX;
      next_st.lp_hdx = LINK_PARTNER_1000T_HDX;
      next_st.fe_locked = FE_LOCKED;
      next_st.fe_link = FE_LINK_UP;

      // Latched bits: a read clears, a fresh event in the same cycle wins
      next_st.ms_fault = MS_FAULT_EVT | (st.ms_fault & ~rd_gst);
      next_st.fe_lock_err = FE_LOCK_ERR_EVT | (st.fe_lock_err & ~rd_fst);
      next_st.fe_disc = FE_DISCONNECT_EVT | (st.fe_disc & ~rd_fst);
      next_st.fe_rx_err = FE_RX_ERR_EVT | (st.fe_rx_err & ~rd_fst);
      next_st.fe_tx_err = FE_TX_ERR_EVT | (st.fe_tx_err & ~rd_fst);
      next_st.fe_ssd_err = FE_START_STREAM_DELIMITER_ERR_EVT | (st.fe_ssd_err & ~rd_fst);
      next_st.fe_esd_err = FE_END_STREAM_DELIMITER_ERR_EVT | (st.fe_esd_err & ~rd_fst);

      // Idle error count saturates so a long burst never wraps to a small value
      if (rd_gst) begin
         next_st.idle_cnt = IDLE_ERR_EVT ? 8'h01 : 8'h00;
      end else if (IDLE_ERR_EVT && (st.idle_cnt != gpcs_pkg::IDLE_CNT_MAX)) begin
         next_st.idle_cnt = st.idle_cnt + 8'h01;
      end

      // Read data reflects the state before this cycle's clear
      next_st.rdata = st.rdata;
      if (REG_RD) begin
         unique case (REG_ADDR)
            gpcs_pkg::ADDR_GIG_CONTROL: next_st.rdata = st.ctrl;
            gpcs_pkg::ADDR_GIG_STATUS: next_st.rdata = gst_word;
            gpcs_pkg::ADDR_GIG_STATUS_EXT_ONE: next_st.rdata = gpcs_pkg::GST_EXT_ONE_VALUE;
            gpcs_pkg::ADDR_FAST_ETH_STATUS_EXT: next_st.rdata = fst_word;
            default: next_st.rdata = 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         st <= '0;
         st.ctrl <= gpcs_pkg::CTL_RESET;
         st.ctrl[gpcs_pkg::CTL_ADV_FDX] <= CONFIG_STRAP_VALUE[1];
         st.ctrl[gpcs_pkg::CTL_ADV_HDX] <= CONFIG_STRAP_VALUE[0];
         st.ms_master <= gpcs_pkg::MS_MASTER_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_RDATA = st.rdata;
   assign TEST_MODE = st.ctrl[gpcs_pkg::CTL_TEST_MODE_LSB +: 3];
   assign MS_MANUAL = st.ctrl[gpcs_pkg::CTL_MS_MANUAL];
   assign MS_REQ_MASTER = st.ms_req_master;
   assign PORT_MULTI = st.ctrl[gpcs_pkg::CTL_PORT_MULTI];
   assign ADV_1000T_FDX = st.ctrl[gpcs_pkg::CTL_ADV_FDX];
   assign ADV_1000T_HDX = st.ctrl[gpcs_pkg::CTL_ADV_HDX];

endmodule

// file: tb/gpcs_regs_monitor.sv
// Checker for the gigabit PHY control and status registers.
// Assumes a single MCLK domain and synchronous active-high RST.
module gpcs_regs_monitor (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [4:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic [2:0] TEST_MODE,
   input wire logic MS_MANUAL,
   input wire logic MS_REQ_MASTER,
   input wire logic PORT_MULTI,
   input wire logic ADV_1000T_FDX,
   input wire logic ADV_1000T_HDX
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   wire logic cw = REG_WR && REG_ADDR == 5'h09;
   wire logic [6:0] ctl = {TEST_MODE, MS_MANUAL, PORT_MULTI, ADV_1000T_FDX, ADV_1000T_HDX};
   AST_TEST_MODE: assert property (cw |=> TEST_MODE == $past(REG_WDATA[15:13]))
      else $error("test mode not taken");
   AST_MS_ROLE: assert property (cw |=> {MS_MANUAL, MS_REQ_MASTER} == $past({REG_WDATA[12], &REG_WDATA[12:11]}))
      else $error("role bits not taken");
   AST_PORT_ADV: assert property (cw |=> {PORT_MULTI, ADV_1000T_FDX, ADV_1000T_HDX} == $past(REG_WDATA[10:8]))
      else $error("port or advert bits not taken");
   AST_REQ_NEEDS_MANUAL: assert property (MS_REQ_MASTER |-> MS_MANUAL)
      else $error("master request without manual mode");
   AST_CTL_HOLD: assert property (!cw |=> $stable({ctl, MS_REQ_MASTER}))
      else $error("control outputs moved without a write");
   AST_CTL_READ: assert property (REG_RD && REG_ADDR == 5'h09 |=> {REG_RDATA[15:12], REG_RDATA[10:8]} == $past(ctl))
      else $error("control readback differs from outputs");
   AST_CAPS: assert property (REG_RD && REG_ADDR == 5'h0f |=> REG_RDATA == 16'h3000)
      else $error("capability word wrong");
   AST_UNMAPPED: assert property (REG_RD && !(REG_ADDR inside {5'h09, 5'h0a, 5'h0f, 5'h10}) |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
endmodule
bind gpcs_regs gpcs_regs_monitor gpcs_regs_monitor_inst (.*);

// file: tb/test_gpcs_regs.sv
// Self-checking bench for the gigabit PHY control and status registers.
// Assumes gpcs_regs and its bound checker; all inputs are driven on MCLK rising edges.
module test_gpcs_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 0, RST = 1, REG_WR = 0, REG_RD = 0;
   logic [4:0] REG_ADDR = 5'h00;
   logic [15:0] REG_WDATA = 16'h0000, REG_RDATA;
   logic [1:0] CONFIG_STRAP_VALUE = 2'h2;
   logic [2:0] TEST_MODE;
   logic MS_MANUAL, MS_REQ_MASTER, PORT_MULTI, ADV_1000T_FDX, ADV_1000T_HDX;
   logic MS_FAULT_EVT = 0, MS_RESOLVED_MASTER = 1, LOCAL_RX_OK = 0, REMOTE_RX_OK = 0, IDLE_ERR_EVT = 0;
   logic LINK_PARTNER_1000T_FDX = 0, LINK_PARTNER_1000T_HDX = 0, FE_LOCKED = 0, FE_LINK_UP = 0;
   logic FE_LOCK_ERR_EVT = 0, FE_DISCONNECT_EVT = 0, FE_RX_ERR_EVT = 0, FE_TX_ERR_EVT = 0;
   logic FE_START_STREAM_DELIMITER_ERR_EVT = 0, FE_END_STREAM_DELIMITER_ERR_EVT = 0;
   int n_mismatch = 0, cmp_count = 0, cycles = 0;
   wire logic [15:0] outs = {8'h00, TEST_MODE, MS_MANUAL, MS_REQ_MASTER, PORT_MULTI, ADV_1000T_FDX, ADV_1000T_HDX};
   gpcs_regs gpcs_regs_inst (.*);
   always #10 MCLK = ~MCLK;
   task automatic complete_run();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge MCLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask
   // Read data is looked at mid-cycle, after the taking edge has landed
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge MCLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      @(negedge MCLK);
      chk(REG_RDATA, exp);
   endtask
   task automatic t_reset();
      chk(outs, 16'h0006);
      rd(5'h09, 16'h0600);
      rd(5'h0a, 16'h4000);
      rd(5'h0f, 16'h3000);
      rd(5'h10, 16'h0000);
      rd(5'h05, 16'h0000);
   endtask
   // Every defined test code, with the role bits walked through all four pairs
   task automatic t_control();
      logic [15:0] d;
      for (logic [2:0] i = 0; i < 5; i++) begin
         d = {i, i[1], i[0], ~i[0], i[0], i[1], 8'h5a};
         // Only the defined codes 000..100 are written to the test-mode field
         wr(5'h09, d);
         // Outputs move in the NBA region of the taking edge, so look half a cycle later
         @(negedge MCLK);
         chk(outs, {8'h00, d[15:12], d[12] & d[11], d[10:8]});
         rd(5'h09, d);
      end
   endtask
   task automatic t_status();
      @(posedge MCLK);
      {MS_RESOLVED_MASTER, LOCAL_RX_OK, REMOTE_RX_OK, LINK_PARTNER_1000T_FDX, FE_LOCKED, FE_LINK_UP} <= 6'h1f;
      {MS_FAULT_EVT, FE_LOCK_ERR_EVT, FE_DISCONNECT_EVT, FE_RX_ERR_EVT, FE_TX_ERR_EVT} <= 5'h1f;
      {FE_START_STREAM_DELIMITER_ERR_EVT, FE_END_STREAM_DELIMITER_ERR_EVT, IDLE_ERR_EVT} <= 3'h7;
      @(posedge MCLK);
      {MS_FAULT_EVT, FE_LOCK_ERR_EVT, FE_DISCONNECT_EVT, FE_RX_ERR_EVT, FE_TX_ERR_EVT} <= 5'h00;
      {FE_START_STREAM_DELIMITER_ERR_EVT, FE_END_STREAM_DELIMITER_ERR_EVT} <= 2'h0;
      repeat (2) @(posedge MCLK);
      IDLE_ERR_EVT <= 1'b0;
      wr(5'h0a, 16'hffff);
      rd(5'h0a, 16'hb803);
      rd(5'h0a, 16'h3800);
      rd(5'h10, 16'hff00);
      rd(5'h10, 16'h9000);
      @(posedge MCLK);
      {FE_LOCKED, FE_LINK_UP} <= 2'h0;
      rd(5'h10, 16'h0000);
   endtask
   // An event at the very edge that takes the read must survive the clear
   task automatic t_same_edge();
      @(posedge MCLK);
      REG_RD <= 1'b1;
      REG_ADDR <= 5'h0a;
      {MS_FAULT_EVT, IDLE_ERR_EVT} <= 2'h3;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      {MS_FAULT_EVT, IDLE_ERR_EVT} <= 2'h0;
      @(negedge MCLK);
      chk(REG_RDATA, 16'h3800);
      rd(5'h0a, 16'hb801);
      @(posedge MCLK);
      IDLE_ERR_EVT <= 1'b1;
      repeat (300) @(posedge MCLK);
      IDLE_ERR_EVT <= 1'b0;
      rd(5'h0a, 16'h38ff);
   endtask
   initial begin
      repeat (16) @(posedge MCLK);
      RST <= 1'b0;
      t_reset();
      t_control();
      t_status();
      t_same_edge();
      complete_run();
   end
   // The whole sequence needs well under a thousand cycles
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
endmodule
